// ### hw/mii_recon_defs.vh
// Shared constants for the nibble-mapping reconciliation block
//
// Behaviour
// - Each MAC bit rides one TXD line under TX_EN
// - Data complete ends the frame by dropping TX_EN
// - Transmit nibbles follow the PHY transmit clock
// - One TXD/TX_EN update per four bits
// - MAC receive bits come from RXD under RX_DV
// - Every received nibble gives four bit indications
// - Receive nibbles follow the PHY receive clock
// - Carrier status from CRS, indicate each change
// - RX_DV low: carrier tracks CRS edges
// - RX_DV fall after both forces carrier off
// - COL gives signal error, indicate each change
// - RX_ER with RX_DV forces frame check error
// - Replace final nibble with guaranteed bad value
// - TX_ER optional, only to corrupt frames
// - TX_EN spans exactly first to last nibble
// - Undriven TX_ER stays low always
`ifndef MII_RECON_DEFS_VH
`define MII_RECON_DEFS_VH

// Nibble geometry
`define NIB_W          4
`define NIB_ZERO       4'h0
// Bit counter width and the count that means a whole nibble
`define BCNT_W         3
`define BCNT_ZERO      3'h0
`define BCNT_ONE       3'h1
`define BCNT_FULL      3'h4
// Mask applied to the last nibble of a frame received with an error
`define CRC_SPOIL_MASK 4'hF
// Receive-side synchroniser bundle: clock, col, crs, er, dv, data
`define RXS_W          9
`define RXS_CLK        8
`define RXS_COL        7
`define RXS_CRS        6
`define RXS_ER         5
`define RXS_DV         4
`define RXS_D_HI       3
`define RXS_D_LO       0
// Off and on values of single bits
`define BIT_OFF        1'h0
`define BIT_ON         1'h1

`endif

// ### hw/link_sync.v
// Two flip-flop synchroniser for a bundle of pins
`timescale 1ns/100ps
`default_nettype none

module link_sync #(
    parameter W = 1
) (
    input  wire         ref_clk_i,
    input  wire         reset_i,
    input  wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);

    // First stage, read only by the second stage
    reg [W-1:0] meta_r;
    // Second stage, safe for logic
    reg [W-1:0] sync_r;

    // Plain two-stage chain; reset clears both stages
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            meta_r <= {W{1'h0}};
            sync_r <= {W{1'h0}};
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule

`default_nettype wire

// ### hw/edge_find.v
// Rise and fall detector for an already synchronised level
`timescale 1ns/100ps
`default_nettype none

module edge_find (
    input  wire ref_clk_i,
    input  wire reset_i,
    input  wire level_i,
    output wire rise_o,
    output wire fall_o
);

    // Level one cycle ago
    reg prev_r;

    // Track the previous level
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            prev_r <= 1'h0;
        end else begin
            prev_r <= level_i;
        end
    end

    // One-cycle pulses on each change
    assign rise_o = level_i & ~prev_r;
    assign fall_o = ~level_i & prev_r;

endmodule

`default_nettype wire

// ### hw/mii_recon.v
// Reconciliation logic between a bit-serial MAC and a nibble-wide PHY link
`timescale 1ns/100ps
`default_nettype none
`include "mii_recon_defs.vh"

module mii_recon (
    input  wire                ref_clk_i,
    input  wire                reset_i,
    // MAC transmit bit requests
    input  wire                tx_bit_valid_i,
    input  wire                tx_bit_i,
    output wire                tx_bit_ready_o,
    input  wire                tx_done_i,
    input  wire                tx_corrupt_i,
    // MAC receive bit indications and status
    output wire                rx_bit_valid_o,
    output wire                rx_bit_o,
    output wire                carrier_on_o,
    output wire                carrier_ind_o,
    output wire                sig_err_o,
    output wire                sig_ind_o,
    // PHY transmit side
    input  wire                mii_tx_clk_i,
    output wire [`NIB_W-1:0]   mii_txd_o,
    output wire                mii_tx_en_o,
    output wire                mii_tx_er_o,
    // PHY receive side
    input  wire                mii_rx_clk_i,
    input  wire [`NIB_W-1:0]   mii_rxd_i,
    input  wire                mii_rx_dv_i,
    input  wire                mii_rx_er_i,
    input  wire                mii_crs_i,
    input  wire                mii_col_i
);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------

    // Synchronised transmit clock
    wire                tx_clk_s;
    // Synchronised receive bundle
    wire [`RXS_W-1:0]   rx_s;
    // Unpacked receive bundle
    wire                rx_clk_s;
    wire                col_s;
    wire                crs_s;
    wire                rx_er_s;
    wire                rx_dv_s;
    wire [`NIB_W-1:0]   rxd_s;
    // Edge pulses
    wire                tx_rise;
    wire                rx_fall;
    wire                crs_rise;
    wire                crs_fall;
    wire                col_rise;
    wire                col_fall;
    wire                dv_fall;

    // Transmit clock passes its own two-stage chain
    link_sync #(
        .W (1)
    ) u_tx_sync (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .async_i   (mii_tx_clk_i),
        .sync_o    (tx_clk_s)
    );

    // Receive clock travels with its data so both see the same delay
    link_sync #(
        .W (`RXS_W)
    ) u_rx_sync (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .async_i   ({mii_rx_clk_i, mii_col_i, mii_crs_i,
                     mii_rx_er_i, mii_rx_dv_i, mii_rxd_i}),
        .sync_o    (rx_s)
    );

    assign rx_clk_s = rx_s[`RXS_CLK];
    assign col_s    = rx_s[`RXS_COL];
    assign crs_s    = rx_s[`RXS_CRS];
    assign rx_er_s  = rx_s[`RXS_ER];
    assign rx_dv_s  = rx_s[`RXS_DV];
    assign rxd_s    = rx_s[`RXS_D_HI:`RXS_D_LO];

    edge_find u_tx_edge (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .level_i   (tx_clk_s),
        .rise_o    (tx_rise),
        .fall_o    ()
    );

    edge_find u_rx_edge (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .level_i   (rx_clk_s),
        .rise_o    (),
        .fall_o    (rx_fall)
    );

    // Carrier sense edges
    edge_find u_crs_edge (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .level_i   (crs_s),
        .rise_o    (crs_rise),
        .fall_o    (crs_fall)
    );

    // Collision edges
    edge_find u_col_edge (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .level_i   (col_s),
        .rise_o    (col_rise),
        .fall_o    (col_fall)
    );

    // Data valid fall, used for carrier only
    edge_find u_dv_edge (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .level_i   (rx_dv_s),
        .rise_o    (),
        .fall_o    (dv_fall)
    );

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------

    // Bits gathered for the next nibble
    reg [`NIB_W-1:0]   tx_acc_r;
    // Number of gathered bits
    reg [`BCNT_W-1:0]  tx_cnt_r;
    // Frame end requested, waiting for a clock edge
    reg                tx_done_r;
    // Link output registers
    reg [`NIB_W-1:0]   txd_r;
    reg                tx_en_r;
    reg                tx_er_r;
    // Nibble complete
    wire               tx_full;
    // Bit taken this cycle
    wire               tx_take;

    assign tx_full = (tx_cnt_r == `BCNT_FULL);
    // Refuse bits once a nibble waits or the frame is closing
    assign tx_bit_ready_o = ~tx_full & ~tx_done_r;
    assign tx_take = tx_bit_valid_i & tx_bit_ready_o;

    // Gather bits, present nibbles on transmit clock rises.
    // Outputs change about three cycles after the PHY's sampling
    // edge, well inside the half period, so the PHY sees stable data.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            tx_acc_r  <= `NIB_ZERO;
            tx_cnt_r  <= `BCNT_ZERO;
            tx_done_r <= `BIT_OFF;
            txd_r     <= `NIB_ZERO;
            tx_en_r   <= `BIT_OFF;
            tx_er_r   <= `BIT_OFF;
        end else begin
            if (tx_rise && tx_full) begin
                txd_r    <= tx_acc_r;
                tx_en_r  <= `BIT_ON;
                tx_er_r  <= tx_corrupt_i;
                tx_cnt_r <= `BCNT_ZERO;
                tx_acc_r <= `NIB_ZERO;
            end else if (tx_rise) begin
                // Enable drops right after last nibble
                txd_r    <= `NIB_ZERO;
                tx_en_r  <= `BIT_OFF;
                tx_er_r  <= `BIT_OFF;
                if (tx_done_r) begin
                    // Partial nibble is dropped with the frame
                    tx_cnt_r  <= `BCNT_ZERO;
                    tx_acc_r  <= `NIB_ZERO;
                    tx_done_r <= `BIT_OFF;
                end else if (tx_take) begin
                    tx_acc_r[tx_cnt_r[1:0]] <= tx_bit_i;
                    tx_cnt_r <= tx_cnt_r + `BCNT_ONE;
                end
            end else if (tx_take) begin
                tx_acc_r[tx_cnt_r[1:0]] <= tx_bit_i;
                tx_cnt_r <= tx_cnt_r + `BCNT_ONE;
            end
            // End request wins over its own clear
            if (tx_done_i) begin
                tx_done_r <= `BIT_ON;
            end
        end
    end

    assign mii_txd_o   = txd_r;
    assign mii_tx_en_o = tx_en_r;
    assign mii_tx_er_o = tx_er_r;

    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------

    // Last nibble held back so it can be spoiled at frame end
    reg [`NIB_W-1:0]   rx_hold_r;
    reg                rx_hold_v_r;
    // Error seen in the current frame
    reg                rx_err_r;
    // Nibble being shifted out to the MAC
    reg [`NIB_W-1:0]   rx_out_r;
    // Bits still to shift
    reg [`BCNT_W-1:0]  rx_left_r;
    // MAC bit outputs
    reg                rx_bit_r;
    reg                rx_bit_v_r;

    // Sample in mid period on the falling edge; the PHY changes data
    // on the rise, and the clock shares the data's sync delay.
    // Holding one nibble back costs one nibble of latency but lets
    // the final nibble be replaced without knowing the frame length.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            rx_hold_r   <= `NIB_ZERO;
            rx_hold_v_r <= `BIT_OFF;
            rx_err_r    <= `BIT_OFF;
            rx_out_r    <= `NIB_ZERO;
            rx_left_r   <= `BCNT_ZERO;
            rx_bit_r    <= `BIT_OFF;
            rx_bit_v_r  <= `BIT_OFF;
        end else if (rx_fall && rx_dv_s) begin
            rx_hold_r   <= rxd_s;
            rx_hold_v_r <= `BIT_ON;
            if (rx_er_s) begin
                rx_err_r <= `BIT_ON;
            end
            // Release the previously held nibble
            if (rx_hold_v_r) begin
                rx_out_r  <= rx_hold_r;
                rx_left_r <= `BCNT_FULL;
            end
            rx_bit_v_r <= `BIT_OFF;
        end else if (rx_fall && rx_hold_v_r) begin
            if (rx_err_r) begin
                rx_out_r <= rx_hold_r ^ `CRC_SPOIL_MASK;
            end else begin
                rx_out_r <= rx_hold_r;
            end
            rx_left_r   <= `BCNT_FULL;
            rx_hold_v_r <= `BIT_OFF;
            rx_err_r    <= `BIT_OFF;
            rx_bit_v_r  <= `BIT_OFF;
        end else if (rx_left_r != `BCNT_ZERO) begin
            rx_bit_r   <= rx_out_r[0];
            rx_bit_v_r <= `BIT_ON;
            rx_out_r   <= {`BIT_OFF, rx_out_r[`NIB_W-1:1]};
            rx_left_r  <= rx_left_r - `BCNT_ONE;
        end else begin
            rx_bit_v_r <= `BIT_OFF;
        end
    end

    assign rx_bit_o       = rx_bit_r;
    assign rx_bit_valid_o = rx_bit_v_r;

    // ------------------------------------------------------------
    // Carrier and collision status
    // ------------------------------------------------------------

    // Carrier status toward the MAC
    reg  carrier_r;
    reg  carrier_nxt;
    // Change pulse
    reg  carrier_ind_r;
    // Carrier and valid have been high together
    reg  both_seen_r;
    // Collision status and change pulse
    reg  sig_err_r;
    reg  sig_ind_r;

    // Next carrier value; the forced drop outranks CRS edges
    always @* begin
        carrier_nxt = carrier_r;
        if (dv_fall && both_seen_r) begin
            carrier_nxt = `BIT_OFF;
        end else if (crs_rise) begin
            carrier_nxt = `BIT_ON;
        end else if (crs_fall) begin
            carrier_nxt = `BIT_OFF;
        end
    end

    // Status registers and one-cycle change pulses
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            carrier_r     <= `BIT_OFF;
            carrier_ind_r <= `BIT_OFF;
            both_seen_r   <= `BIT_OFF;
            sig_err_r     <= `BIT_OFF;
            sig_ind_r     <= `BIT_OFF;
        end else begin
            carrier_r     <= carrier_nxt;
            carrier_ind_r <= (carrier_nxt != carrier_r);
            // Armed once both are high, disarmed by the valid fall
            if (dv_fall) begin
                both_seen_r <= `BIT_OFF;
            end else if (crs_s && rx_dv_s) begin
                both_seen_r <= `BIT_ON;
            end
            sig_err_r <= col_s;
            sig_ind_r <= col_rise | col_fall;
        end
    end

    assign carrier_on_o  = carrier_r;
    assign carrier_ind_o = carrier_ind_r;
    assign sig_err_o     = sig_err_r;
    assign sig_ind_o     = sig_ind_r;

endmodule

`default_nettype wire

// ### test/mii_recon_props.sv
// Port-level assertions for the reconciliation block
`timescale 1ns/100ps
`default_nettype none
module mii_recon_props (
    input wire       ref_clk_i,
    input wire       reset_i,
    input wire       rx_bit_valid_o,
    input wire       carrier_on_o,
    input wire       carrier_ind_o,
    input wire       sig_err_o,
    input wire       sig_ind_o,
    input wire [3:0] mii_txd_o,
    input wire       mii_tx_en_o,
    input wire       mii_tx_er_o,
    input wire       mii_rx_dv_i,
    input wire       mii_crs_i,
    input wire       mii_col_i
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    tx_er_gated_a: assert property (mii_tx_er_o |-> mii_tx_en_o)
        else $error("tx error outside frame");
    carrier_pulse_a: assert property
        (carrier_ind_o == (carrier_on_o != $past(carrier_on_o)))
        else $error("carrier pulse wrong");
    signal_pulse_a: assert property
        (sig_ind_o == (sig_err_o != $past(sig_err_o)))
        else $error("signal pulse wrong");
    col_follow_a: assert property
        ($rose(mii_col_i) |-> ##[1:4] sig_err_o)
        else $error("collision not reported");
    carrier_rise_a: assert property
        ($rose(mii_crs_i) && !mii_rx_dv_i |-> ##[1:5] carrier_on_o)
        else $error("carrier not raised");
    dv_fall_off_a: assert property
        ($fell(mii_rx_dv_i) && mii_crs_i |-> ##[1:6] !carrier_on_o)
        else $error("carrier kept after valid fall");
    rx_burst_a: assert property
        ($rose(rx_bit_valid_o) |-> rx_bit_valid_o[*4] ##1 !rx_bit_valid_o)
        else $error("bit burst not four");
    tx_hold_a: assert property
        ($changed({mii_txd_o, mii_tx_en_o}) |=>
         $stable({mii_txd_o, mii_tx_en_o})[*5])
        else $error("transmit nibble changed early");
endmodule
bind mii_recon mii_recon_props u_props (
    .ref_clk_i      (ref_clk_i),
    .reset_i        (reset_i),
    .rx_bit_valid_o (rx_bit_valid_o),
    .carrier_on_o   (carrier_on_o),
    .carrier_ind_o  (carrier_ind_o),
    .sig_err_o      (sig_err_o),
    .sig_ind_o      (sig_ind_o),
    .mii_txd_o      (mii_txd_o),
    .mii_tx_en_o    (mii_tx_en_o),
    .mii_tx_er_o    (mii_tx_er_o),
    .mii_rx_dv_i    (mii_rx_dv_i),
    .mii_crs_i      (mii_crs_i),
    .mii_col_i      (mii_col_i)
);
`default_nettype wire

// ### test/phy_model.sv
// Behavioural link partner: clocks, capture and receive frames
`timescale 1ns/100ps
`default_nettype none
module phy_model (
    output logic       tx_clk_o,
    output logic       rx_clk_o,
    input  wire  [3:0] txd_i,
    input  wire        tx_en_i,
    input  wire        tx_er_i,
    output logic [3:0] rxd_o,
    output logic       rx_dv_o,
    output logic       rx_er_o,
    output logic       crs_o,
    output logic       col_o
);
    logic [4:0] txq[$];  // Captured error and nibble
    logic [3:0] rxq[$];  // Nibbles still to send
    logic       go;      // Frame in progress
    logic       er_req;  // Flag one nibble as errored
    initial begin
        tx_clk_o = 1'b0;
        rx_clk_o = 1'b0;
        rxd_o = 4'h5;
        {rx_dv_o, rx_er_o, crs_o, col_o, go, er_req} = 6'h00;
    end
    always #400 tx_clk_o = ~tx_clk_o;
    // Receive clock, free running, own phase
    initial #130 forever #400 rx_clk_o = ~rx_clk_o;
    // Nibble taken on transmit clock rise
    always @(posedge tx_clk_o) begin
        if (tx_en_i === 1'b1) txq.push_back({tx_er_i, txd_i});
    end
    // Drive receive lines on clock rise
    always @(posedge rx_clk_o) begin
        if (go && rxq.size() > 0) begin
            rx_er_o <= er_req && rxq.size() == 2;
            rx_dv_o <= 1'b1;
            rxd_o <= rxq.pop_front();
        end else begin
            rx_er_o <= 1'b0;
            rx_dv_o <= 1'b0;
            // Released data toggles so stale values never match
            rxd_o <= ~rxd_o;
        end
    end
    // Carrier first, data after lock; carrier left high
    task automatic rx_frame(input logic er);
        er_req = er;
        crs_o = 1'b1;
        repeat (2) @(posedge rx_clk_o);
        // Non-blocking so the driver sees it at the next rise, never this one
        go <= 1'b1;
        wait (rxq.size() == 0);
        go = 1'b0;
        @(negedge rx_dv_o);
    endtask
    task automatic set_lines(input logic crs, input logic col);
        crs_o = crs;
        col_o = col;
    endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the reconciliation block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic       ref_clk_i, reset_i, tx_bit_valid_i, tx_bit_i;
    logic       tx_done_i, tx_corrupt_i;
    wire        tx_bit_ready_o, rx_bit_valid_o, rx_bit_o, carrier_on_o;
    wire        carrier_ind_o, sig_err_o, sig_ind_o, mii_tx_clk_i;
    wire        mii_tx_en_o, mii_tx_er_o, mii_rx_clk_i, mii_rx_dv_i;
    wire        mii_rx_er_i, mii_crs_i, mii_col_i;
    wire  [3:0] mii_txd_o, mii_rxd_i;
    int         err_total, comparisons;
    logic       rxb[$];   // Bits seen by the MAC
    logic [3:0] nib[$];   // Nibbles of the current frame
    mii_recon dut (.ref_clk_i, .reset_i, .tx_bit_valid_i, .tx_bit_i,
        .tx_bit_ready_o, .tx_done_i, .tx_corrupt_i, .rx_bit_valid_o,
        .rx_bit_o, .carrier_on_o, .carrier_ind_o, .sig_err_o, .sig_ind_o,
        .mii_tx_clk_i, .mii_txd_o, .mii_tx_en_o, .mii_tx_er_o,
        .mii_rx_clk_i, .mii_rxd_i, .mii_rx_dv_i, .mii_rx_er_i,
        .mii_crs_i, .mii_col_i);
    phy_model phy (.tx_clk_o(mii_tx_clk_i), .rx_clk_o(mii_rx_clk_i),
        .txd_i(mii_txd_o), .tx_en_i(mii_tx_en_o), .tx_er_i(mii_tx_er_o),
        .rxd_o(mii_rxd_i), .rx_dv_o(mii_rx_dv_i), .rx_er_o(mii_rx_er_i),
        .crs_o(mii_crs_i), .col_o(mii_col_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    // Collect every bit handed to the MAC, mid cycle where it has settled
    always @(negedge ref_clk_i) begin
        if (rx_bit_valid_o === 1'b1) rxb.push_back(rx_bit_o);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Bit i of a nibble, earliest on the lowest line
    function automatic logic nib_bit(input logic [3:0] n, input int i);
        return n[i];
    endfunction
    // One bit offered, held until taken
    task automatic send_bit(input logic b);
        @(negedge ref_clk_i);
        tx_bit_valid_i = 1'b1;
        tx_bit_i = b;
        while (tx_bit_ready_o !== 1'b1) @(negedge ref_clk_i);
        @(posedge ref_clk_i);
    endtask
    // Frame of n nibbles, extra trailing bits must be dropped
    task automatic tx_frame(input int n, input logic cor, input int extra);
        nib = {};
        phy.txq = {};
        @(negedge ref_clk_i);
        tx_corrupt_i = cor;
        for (int k = 0; k < n; k++) nib.push_back($urandom);
        for (int k = 0; k < 4 * n + extra; k++)
            send_bit(k < 4 * n ? nib_bit(nib[k / 4], k % 4) : $urandom);
        @(negedge ref_clk_i);
        tx_bit_valid_i = 1'b0;
        tx_done_i = 1'b1;
        @(negedge ref_clk_i);
        tx_done_i = 1'b0;
        repeat (40) @(negedge ref_clk_i);
        check(phy.txq.size(), n);
        foreach (nib[k]) check(phy.txq[k], {cor, nib[k]});
        $display("tx frame of %0d nibbles done", n);
    endtask
    // Received frame, optional error, carrier held past valid
    task automatic rx_test(input int n, input logic er);
        rxb = {};
        nib = {};
        for (int k = 0; k < n; k++) nib.push_back($urandom);
        phy.rxq = nib;
        phy.rx_frame(er);
        repeat (16) @(negedge ref_clk_i);
        check(carrier_on_o, 1'b0);
        // Sense must fall visibly before the next test raises it again
        phy.set_lines(1'b0, 1'b0);
        repeat (8) @(negedge ref_clk_i);
        check(carrier_on_o, 1'b0);
        check(rxb.size(), 4 * n);
        for (int k = 0; k < 4 * n; k++)
            check(rxb[k], nib_bit((er && k / 4 == n - 1) ?
                ~nib[k / 4] : nib[k / 4], k % 4));
        $display("rx frame of %0d nibbles done", n);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog well past the expected run length
    initial begin
        #800000;
        err_total++;
        end_of_test();
    end
    initial begin
        {tx_bit_valid_i, tx_bit_i, tx_done_i, tx_corrupt_i} = 4'h0;
        reset_i = 1'b1;
        err_total = 0;
        comparisons = 0;
        void'($urandom(66));
        repeat (5) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        reset_i = 1'b0;
        tx_frame(1, 1'b1, 3);
        tx_frame(8, 1'b0, 0);
        for (int i = 0; i < 3; i++)
            tx_frame($urandom_range(2, 9), $urandom, $urandom_range(0, 3));
        rx_test(3, 1'b1);
        for (int i = 0; i < 3; i++) rx_test($urandom_range(3, 9), $urandom);
        phy.set_lines(1'b1, 1'b1);
        repeat (8) @(negedge ref_clk_i);
        check({carrier_on_o, sig_err_o}, 2'h3);
        phy.set_lines(1'b0, 1'b0);
        repeat (8) @(negedge ref_clk_i);
        check({carrier_on_o, sig_err_o}, 2'h0);
        $display("status lines done");
        end_of_test();
    end
endmodule
`default_nettype wire
